// [rtl/io_lines.sv]
// Top of the camera I/O line logic: trigger input, output-only line, bidirectional line, registers.
// Assumes the register master keeps the strobe protocol and the status sources are synchronous.
// Behaviour
// - trigger input has selectable active level, low active after reset.
// - bidirectional line direction is selectable, output after reset.
// - bidirectional line as input has selectable active level, low after reset.
// - bidirectional output value comes from an eight-way source selector.
// - with source off the bidirectional line is accepted as input in any direction.
// - output-only line drives a selected source with selectable level, low after reset.
`timescale 1ns/1ps
module io_lines #(
    parameter int MIN_PULSE_CYCLES = io_lines_pkg::MIN_PULSE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [io_lines_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [io_lines_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [io_lines_pkg::DATA_W-1:0] reg_rdata,
    input wire logic trigger_in_line,
    output logic trigger_active,
    input wire logic bidir_line_i,
    output logic bidir_line_o,
    output logic bidir_line_oe,
    output logic bidir_in_active,
    output logic bidir_in_valid,
    output logic out_only_line,
    input wire logic timer_zero_running,
    input wire logic acquisition_running,
    input wire logic frame_trigger_pending,
    input wire logic frame_in_progress,
    input wire logic frame_sending,
    input wire logic exposure_running
);
    import io_lines_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic [SEL_W-1:0] bidir_sel_reg;
    logic [SEL_W-1:0] out_sel_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic bidir_o_reg;
    logic bidir_oe_reg;
    logic bidir_valid_reg;
    logic out_only_reg;
    logic warm_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [7:0] source_vec;
    logic bidir_level;
    logic out_level;
    logic bidir_off;
    logic bidir_drive;
    logic write_ctrl;
    logic write_source;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] source_word;
    logic [DATA_W-1:0] status_word;

    line_sync_if sync_lines[2] ();

    // trigger input and bidirectional pin pass one conditioner each
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_input
            line_sync u_sync (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .lines(sync_lines[gi])
            );
        end
    endgenerate

    // trigger line with its own active level
    assign sync_lines[0].raw = trigger_in_line;
    assign sync_lines[0].active_high = ctrl_reg[TRIG_POL_BIT];
    // bidirectional line with its own active level
    assign sync_lines[1].raw = bidir_line_i;
    assign sync_lines[1].active_high = ctrl_reg[BIDIR_IN_POL_BIT];

    // Register decode.
    assign write_ctrl = reg_write && (reg_addr == CTRL_OFFSET);
    assign write_source = reg_write && (reg_addr == SOURCE_OFFSET);

    // control register, trigger polarity resets to active low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (write_ctrl) begin
            ctrl_reg <= reg_wdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bidir_sel_reg <= SEL_RESET;
            out_sel_reg <= SEL_RESET;
        end else if (write_source) begin
            bidir_sel_reg <= reg_wdata[BIDIR_SEL_LSB +: SEL_W];
            out_sel_reg <= reg_wdata[OUT_ONLY_SEL_LSB +: SEL_W];
        end
    end

    // eight selectable levels indexed by selector code: off, user bit and six status sources
    assign source_vec = {exposure_running, frame_sending, frame_in_progress, frame_trigger_pending,
                         acquisition_running, timer_zero_running, ctrl_reg[USER_BIT_POS], 1'b0};
    assign bidir_level = source_vec[bidir_sel_reg];
    assign out_level = source_vec[out_sel_reg];

    // source off releases the pin so its level is a valid input
    assign bidir_off = (bidir_sel_reg == SRC_OFF);
    // drive only in output direction with a live source
    assign bidir_drive = (ctrl_reg[BIDIR_DIR_BIT] == DIR_OUTPUT) && !bidir_off;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bidir_o_reg <= 1'b0;
            bidir_oe_reg <= 1'b0;
            bidir_valid_reg <= 1'b0;
        end else begin
            bidir_o_reg <= ~(bidir_level ^ ctrl_reg[BIDIR_OUT_POL_BIT]);
            bidir_oe_reg <= bidir_drive;
            bidir_valid_reg <= !bidir_drive;
        end
    end

    // output-only line with its own polarity
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_only_reg <= 1'b1;
        end else begin
            out_only_reg <= ~(out_level ^ ctrl_reg[OUT_ONLY_POL_BIT]);
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    assign ctrl_word = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
    assign source_word = {{(DATA_W-7){1'b0}}, out_sel_reg, 1'b0, bidir_sel_reg};
    assign status_word = {{(DATA_W-6){1'b0}}, bidir_oe_reg, bidir_o_reg, out_only_reg,
                          bidir_valid_reg, sync_lines[1].active, sync_lines[0].active};
    assign rdata_next = !reg_read ? '0 :
                        (reg_addr == CTRL_OFFSET) ? ctrl_word :
                        (reg_addr == SOURCE_OFFSET) ? source_word :
                        (reg_addr == STATUS_OFFSET) ? status_word : '0;

    // Read data stand for the one cycle after the read strobe.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Marks the first edge after reset so past values are meaningful.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            warm_reg <= 1'b0;
        end else begin
            warm_reg <= 1'b1;
        end
    end

    // Output connections, each straight from a flop.
    assign reg_rdata = rdata_reg;
    assign trigger_active = sync_lines[0].active;
    assign bidir_in_active = sync_lines[1].active;
    assign bidir_line_o = bidir_o_reg;
    assign bidir_line_oe = bidir_oe_reg;
    assign bidir_in_valid = bidir_valid_reg;
    assign out_only_line = out_only_reg;

    a_trig_default: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (ctrl_reg[TRIG_POL_BIT] == 1'b0))
        else $error("Trigger line does not come out of reset active low.");

    a_dir_default: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (ctrl_reg[BIDIR_DIR_BIT] == DIR_OUTPUT))
        else $error("Bidirectional line does not come out of reset as output.");

    a_pol_defaults: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> !ctrl_reg[OUT_ONLY_POL_BIT] && !ctrl_reg[BIDIR_IN_POL_BIT] && !ctrl_reg[BIDIR_OUT_POL_BIT])
        else $error("Line polarities do not come out of reset active low.");

    a_dir_input_release: assert property (@(posedge clk_sys) disable iff (!resetn)
        write_ctrl && (reg_wdata[BIDIR_DIR_BIT] == DIR_INPUT) |=> ##1 !bidir_line_oe && bidir_in_valid)
        else $error("Input direction did not release the bidirectional pin.");

    a_off_input_valid: assert property (@(posedge clk_sys) disable iff (!resetn)
        write_source && (reg_wdata[BIDIR_SEL_LSB +: SEL_W] == SRC_OFF) |=> ##1 bidir_in_valid && !bidir_line_oe)
        else $error("Source off did not make the bidirectional input valid.");

    a_bidir_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        warm_reg && $past(bidir_drive) |-> bidir_line_oe &&
        (bidir_line_o == ~($past(source_vec[bidir_sel_reg]) ^ $past(ctrl_reg[BIDIR_OUT_POL_BIT]))))
        else $error("Bidirectional pin does not drive the selected source.");

    a_out_only_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        warm_reg |-> (out_only_line == ~($past(source_vec[out_sel_reg]) ^ $past(ctrl_reg[OUT_ONLY_POL_BIT]))))
        else $error("Output-only line does not drive the selected source.");

    a_user_bit_out: assert property (@(posedge clk_sys) disable iff (!resetn)
        (out_sel_reg == SRC_USER_BIT) && $stable(out_sel_reg) && $changed(ctrl_reg[USER_BIT_POS])
        && $stable(ctrl_reg[OUT_ONLY_POL_BIT]) |=> $changed(out_only_line))
        else $error("Output-only line did not follow the software user bit.");

endmodule // io_lines

// [rtl/io_lines_pkg.sv]
// Constants shared by the camera I/O line logic: register map, fields, resets, timing.
// Assumes a single 200 MHz system clock and a simple strobed register port.
package io_lines_pkg;

    // Register port geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SOURCE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;

    // Control register field positions.
    localparam int TRIG_POL_BIT = 0;
    localparam int BIDIR_DIR_BIT = 1;
    localparam int BIDIR_IN_POL_BIT = 2;
    localparam int BIDIR_OUT_POL_BIT = 3;
    localparam int OUT_ONLY_POL_BIT = 4;
    localparam int USER_BIT_POS = 5;
    localparam int CTRL_W = 6;

    // Control reset: all polarities active low, bidirectional line set to output.
    localparam logic [5:0] CTRL_RESET = 6'h02;

    // Source register field positions.
    localparam int SEL_W = 3;
    localparam int BIDIR_SEL_LSB = 0;
    localparam int OUT_ONLY_SEL_LSB = 4;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // Status register field positions.
    localparam int ST_TRIG_BIT = 0;
    localparam int ST_BIDIR_IN_BIT = 1;
    localparam int ST_BIDIR_VALID_BIT = 2;
    localparam int ST_OUT_ONLY_BIT = 3;
    localparam int ST_BIDIR_OUT_BIT = 4;
    localparam int ST_BIDIR_OE_BIT = 5;

    // Direction encodings of the line direction select field.
    localparam logic DIR_INPUT = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;

    // Output source selector codes.
    typedef enum logic [2:0] {
        SRC_OFF,
        SRC_USER_BIT,
        SRC_TIMER_ZERO,
        SRC_ACQUISITION,
        SRC_TRIGGER_PENDING,
        SRC_FRAME,
        SRC_SENDING,
        SRC_EXPOSURE
    } line_source_t;

    // Least pulse width the far side must hold on an input line.
    localparam int CLK_MHZ = 200;
    localparam int MIN_PULSE_US = 50;
    localparam int MIN_PULSE_CYCLES = MIN_PULSE_US * CLK_MHZ;

    // Edges from a pin change to the polarity-adjusted flop.
    localparam int SYNC_LATENCY = 3;

endpackage

// [rtl/line_sync_if.sv]
// Carrier between the top and one input-line conditioner.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface line_sync_if;
    logic raw;
    logic active_high;
    logic active;

    modport conditioner (input raw, input active_high, output active);
    modport user (output raw, output active_high, input active);
endinterface

// [rtl/line_sync.sv]
// One input-line conditioner: two-stage synchroniser followed by polarity adjustment.
// Assumes the pin level is asynchronous and the polarity bit is synchronous to clk_sys.
`timescale 1ns/1ps
module line_sync (
    input wire logic clk_sys,
    input wire logic resetn,
    line_sync_if.conditioner lines
);
    import io_lines_pkg::*;

    logic meta_reg;
    logic stable_reg;
    logic active_reg;
    logic [1:0] warm_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            stable_reg <= 1'b0;
        end else begin
            meta_reg <= lines.raw;
            stable_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= ~(stable_reg ^ lines.active_high);
        end
    end

    assign lines.active = active_reg;

    // Counts the edges after reset until the pipeline holds real samples.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            warm_reg <= 2'h0;
        end else if (warm_reg != 2'h3) begin
            warm_reg <= warm_reg + 2'h1;
        end
    end

    a_sync_latency: assert property (@(posedge clk_sys) disable iff (!resetn)
        (warm_reg == 2'h3) |-> (active_reg == ~($past(lines.raw, 3) ^ $past(lines.active_high))))
        else $error("Conditioned line does not follow the pin after three edges.");

    a_polarity_flip: assert property (@(posedge clk_sys) disable iff (!resetn)
        (warm_reg == 2'h3) && $stable(stable_reg) && $changed(lines.active_high) |=> $changed(active_reg))
        else $error("Changing the active level did not invert the conditioned line.");

endmodule // line_sync

// [test/far_side_model.sv]
// Far-side model: external trigger source and the equipment on the bidirectional pin.
// Assumes the bench requests levels; new levels are applied only after the hold span.
`timescale 1ns/1ps
module far_side_model #(
    parameter int HOLD = 16
) (
    input wire logic clk_sys,
    input wire logic want_trig,
    input wire logic want_bidir,
    input wire logic bidir_line_o,
    input wire logic bidir_line_oe,
    output logic trigger_in_line,
    output logic bidir_line_i
);
    logic [7:0] held_reg = 8'h00;
    logic trig_reg = 1'b1;
    logic bidir_reg = 1'b1;

    // pulse hold time
    // Each driven level stands at least HOLD cycles before the next change is applied.
    always_ff @(posedge clk_sys) begin
        if (held_reg < 8'(HOLD)) begin
            held_reg <= held_reg + 8'h01;
        end else if (want_trig != trig_reg || want_bidir != bidir_reg) begin
            trig_reg <= want_trig;
            bidir_reg <= want_bidir;
            held_reg <= 8'h00;
        end
    end

    // The camera's driver wins the wire whenever its enable is high.
    assign trigger_in_line = trig_reg;
    assign bidir_line_i = bidir_line_oe ? bidir_line_o : bidir_reg;
endmodule // far_side_model

// [test/testbench.sv]
// Self-checking bench for the camera I/O line logic, with random and corner cases.
// Assumes io_lines_pkg and the far-side model are compiled first.
`timescale 1ns/1ps
module testbench;
    import io_lines_pkg::*;
    localparam int HOLD = 16;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic trigger_in_line, trigger_active, bidir_line_i, bidir_line_o, bidir_line_oe;
    logic bidir_in_active, bidir_in_valid, out_only_line;
    logic [5:0] srcs = 6'h00;
    logic want_trig = 1'b1;
    logic want_bidir = 1'b1;
    int failures = 0;
    int tests_run = 0;
    integer seed = 32'h5af7760f;

    io_lines #(.MIN_PULSE_CYCLES(HOLD)) u_io_lines (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .trigger_in_line(trigger_in_line), .trigger_active(trigger_active),
        .bidir_line_i(bidir_line_i), .bidir_line_o(bidir_line_o), .bidir_line_oe(bidir_line_oe),
        .bidir_in_active(bidir_in_active), .bidir_in_valid(bidir_in_valid),
        .out_only_line(out_only_line), .timer_zero_running(srcs[0]), .acquisition_running(srcs[1]),
        .frame_trigger_pending(srcs[2]), .frame_in_progress(srcs[3]), .frame_sending(srcs[4]),
        .exposure_running(srcs[5]));

    far_side_model #(.HOLD(HOLD)) u_far_side_model (.clk_sys(clk_sys), .want_trig(want_trig),
        .want_bidir(want_bidir), .bidir_line_o(bidir_line_o), .bidir_line_oe(bidir_line_oe),
        .trigger_in_line(trigger_in_line), .bidir_line_i(bidir_line_i));

    // Free-running 200 MHz system clock.
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One-cycle write strobe.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    // One-cycle read strobe; data is taken in the following cycle.
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Level chosen by a source selector code; off reads as 0.
    function automatic logic pick(input logic [2:0] c, input logic u, input logic [5:0] s);
        return (c == 3'h0) ? 1'b0 : (c == 3'h1) ? u : s[c - 3'h2];
    endfunction

    // Watchdog against a hung run.
    initial begin
        #100000;
        failures++;
        wrap_up();
    end

    // Main sequence: reset values, refused writes, random line settings, user bit, then sync latency.
    initial begin
        logic [31:0] d, ctrl;
        logic [5:0] sv;
        logic [2:0] bs, os;
        logic tw, bw, e_oe, e_o, e_bi;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check({31'h0, out_only_line}, 32'h1);
        check({30'h0, bidir_line_oe, bidir_in_valid}, 32'h1);
        reg_wr(STATUS_OFFSET, 32'hFFFFFFFF);
        reg_wr(8'h0C, 32'hFFFFFFFF);
        reg_rd(CTRL_OFFSET, d);
        check(d, 32'h2);
        reg_rd(SOURCE_OFFSET, d);
        check(d, 32'h0);
        reg_rd(8'h0C, d);
        check(d, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            ctrl = (i < 2) ? (i == 0 ? 32'h2 : 32'h0) : $random(seed);
            sv = $random(seed);
            tw = $random(seed);
            bw = $random(seed);
            bs = i[2:0];
            os = 3'(7 - i);
            @(posedge clk_sys);
            srcs <= sv;
            want_trig <= tw;
            want_bidir <= bw;
            reg_wr(CTRL_OFFSET, ctrl);
            reg_wr(SOURCE_OFFSET, {25'h0, os, 1'b0, bs});
            repeat (2 * HOLD + 8) @(posedge clk_sys);
            #1;
            e_oe = ctrl[BIDIR_DIR_BIT] && bs != 3'h0;
            e_o = pick(bs, ctrl[USER_BIT_POS], sv) ^ ~ctrl[BIDIR_OUT_POL_BIT];
            e_bi = (e_oe ? e_o : bw) ^ ~ctrl[BIDIR_IN_POL_BIT];
            check({31'h0, out_only_line}, {31'h0, pick(os, ctrl[USER_BIT_POS], sv) ^ ~ctrl[4]});
            check({30'h0, bidir_line_oe, bidir_line_o}, {30'h0, e_oe, e_o});
            check({30'h0, bidir_in_valid, bidir_in_active}, {30'h0, ~e_oe, e_bi});
            check({31'h0, trigger_active}, {31'h0, tw ^ ~ctrl[TRIG_POL_BIT]});
            reg_rd(STATUS_OFFSET, d);
            check(d, {26'h0, e_oe, e_o, pick(os, ctrl[USER_BIT_POS], sv) ^ ~ctrl[4], ~e_oe, e_bi, tw ^ ~ctrl[0]});
            reg_rd(CTRL_OFFSET, d);
            check(d, ctrl & 32'h3F);
            $display("test random %0d done", i);
        end
        // Output-only line follows the software user bit, written high then low.
        reg_wr(SOURCE_OFFSET, 32'h10);
        reg_wr(CTRL_OFFSET, 32'h20);
        @(posedge clk_sys);
        #1;
        check({31'h0, out_only_line}, 32'h0);
        reg_wr(CTRL_OFFSET, 32'h00);
        @(posedge clk_sys);
        #1;
        check({31'h0, out_only_line}, 32'h1);
        $display("test user bit done");
        @(posedge clk_sys);
        want_trig <= ~want_trig;
        d = {31'h0, trigger_active};
        @(trigger_in_line);
        repeat (2) @(posedge clk_sys);
        #1;
        check({31'h0, trigger_active}, d);
        @(posedge clk_sys);
        #1;
        check({31'h0, trigger_active}, {31'h0, ~d[0]});
        $display("test sync latency done");
        wrap_up();
    end
endmodule // testbench
